//--- rtl/sld_map.vh
`ifndef SLD_MAP_VH
`define SLD_MAP_VH
`define SLD_ADDR_BK_CTL 8'h49
`define SLD_ADDR_GEN_STS 8'h52
`define SLD_ADDR_ST_CNT 8'h54
`define SLD_ADDR_CRC_LO 8'h55
`define SLD_ADDR_CRC_HI 8'h56
`define SLD_ADDR_PKT_CNT 8'h5C
`define SLD_ADDR_PKT_STS 8'h5D
`define SLD_ADDR_LANE01 8'h5E
`define SLD_ADDR_LANE23 8'h5F
`define SLD_ADDR_CLK_LANE 8'h60
`define SLD_ADDR_ECC_SEL 8'h77
`define SLD_ADDR_BKC_STS 8'h79
`define SLD_ADDR_IRQ_STS 8'h90
`define SLD_ADDR_IRQ_EN 8'h91
`define SLD_ADDR_IRQ_CLR 8'h92
`define SLD_BC_CLR_CRC 0
`define SLD_BC_CLR_ST 1
`define SLD_BC_TMR_LSB 2
`define SLD_BC_TMR_MSB 4
`define SLD_BK_CTL_RST 8'h00
`define SLD_ECC_SEL_RST 8'h00
`define SLD_GS_LINK 0
`define SLD_GS_LOST 1
`define SLD_GS_CRC 2
`define SLD_GS_ST_CRC 3
`define SLD_GS_BKC_ERR 4
`define SLD_IRQ_CRC 0
`define SLD_IRQ_ST 1
`define SLD_IRQ_PKT 2
`define SLD_IRQ_LANE 3
`define SLD_IRQ_BKC 4
`define SLD_IRQ_LOST 5
`endif

//--- rtl/sld_diag_regs.v
// Functional notes
// - control clears crc, self-test errors; holds timer
// - general status shows link and error flags
// - 8-bit self-test crc error counter
// - 16-bit crc count, low byte first
// - packet error count restarts on read
// - packet status flags length, checksum, ecc errors
// - per lane pair sync and control errors
// - clock lane control and lp state errors
// - controller status: timeouts, slave error, response
// - ecc injection select register for test
`timescale 1ns/1ps
`default_nettype none
`include "sld_map.vh"
module sld_diag_regs #(
  parameter CRC_W = 16
) (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire link_up,
  input wire link_lost_ev,
  input wire selftest_active,
  input wire bc_crc_err_ev,
  input wire pkt_err_ev,
  input wire [3:0] pkt_sts_ev,
  input wire [2:0] lane01_ev,
  input wire [2:0] lane23_ev,
  input wire [1:0] clk_lane_ev,
  input wire [3:0] bkc_ev,
  output reg [7:0] ecc_inject_sel,
  output reg [2:0] link_detect_timer,
  output reg irq
);
  reg [7:0] bk_ctl_r;
  reg [7:0] st_cnt_r;
  reg [CRC_W-1:0] crc_cnt_r;
  reg [7:0] pkt_cnt_r;
  reg [3:0] pkt_sts_r;
  reg [2:0] lane01_r;
  reg [2:0] lane23_r;
  reg [1:0] clk_lane_r;
  reg [3:0] bkc_r;
  reg link_lost_r;
  reg crc_flag_r;
  reg st_flag_r;
  reg [5:0] irq_sts_r;
  reg [5:0] irq_en_r;
  reg [7:0] rdata_nxt;
  wire wr_bc = reg_wr && reg_addr == `SLD_ADDR_BK_CTL;
  wire clr_crc = wr_bc && reg_wdata[`SLD_BC_CLR_CRC];
  wire clr_st = wr_bc && reg_wdata[`SLD_BC_CLR_ST];
  wire rd_gs = reg_rd && reg_addr == `SLD_ADDR_GEN_STS;
  wire rd_pkt_cnt = reg_rd && reg_addr == `SLD_ADDR_PKT_CNT;
  wire rd_pkt_sts = reg_rd && reg_addr == `SLD_ADDR_PKT_STS;
  wire rd_l01 = reg_rd && reg_addr == `SLD_ADDR_LANE01;
  wire rd_l23 = reg_rd && reg_addr == `SLD_ADDR_LANE23;
  wire rd_clk = reg_rd && reg_addr == `SLD_ADDR_CLK_LANE;
  wire rd_bkc = reg_rd && reg_addr == `SLD_ADDR_BKC_STS;
  wire wr_irq_clr = reg_wr && reg_addr == `SLD_ADDR_IRQ_CLR;
  wire [5:0] irq_ev = {link_lost_ev, |bkc_ev, |{lane01_ev, lane23_ev, clk_lane_ev},
    pkt_err_ev | (|pkt_sts_ev), bc_crc_err_ev && selftest_active, bc_crc_err_ev};

  // control bits are self-clearing strobes; bits 7:2, including the timer field, are stored
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bk_ctl_r <= `SLD_BK_CTL_RST;
      ecc_inject_sel <= `SLD_ECC_SEL_RST;
      link_detect_timer <= 3'b000;
    end else begin
      if (wr_bc) begin
        bk_ctl_r <= {reg_wdata[7:2], 2'b00};
        link_detect_timer <= reg_wdata[`SLD_BC_TMR_MSB:`SLD_BC_TMR_LSB];
      end
      if (reg_wr && reg_addr == `SLD_ADDR_ECC_SEL)
        ecc_inject_sel <= reg_wdata;
    end
  end

  // counters: clear wins, restarting at 1 if an event coincides, else 0; then saturate
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_cnt_r <= 8'h00;
      crc_cnt_r <= {CRC_W{1'b0}};
      pkt_cnt_r <= 8'h00;
    end else begin
      if (clr_st)
        st_cnt_r <= {7'b0, bc_crc_err_ev && selftest_active};
      else if (bc_crc_err_ev && selftest_active && st_cnt_r != 8'hFF)
        st_cnt_r <= st_cnt_r + 8'h01;
      if (clr_crc)
        crc_cnt_r <= {{(CRC_W-1){1'b0}}, bc_crc_err_ev};
      else if (bc_crc_err_ev && crc_cnt_r != {CRC_W{1'b1}})
        crc_cnt_r <= crc_cnt_r + {{(CRC_W-1){1'b0}}, 1'b1};
      if (rd_pkt_cnt)
        pkt_cnt_r <= {7'b0, pkt_err_ev};
      else if (pkt_err_ev && pkt_cnt_r != 8'hFF)
        pkt_cnt_r <= pkt_cnt_r + 8'h01;
    end
  end

  // sticky flags: read clears (crc and self-test flags clear on control write), a same-cycle event keeps the bit set
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pkt_sts_r <= 4'h0;
      lane01_r <= 3'b000;
      lane23_r <= 3'b000;
      clk_lane_r <= 2'b00;
      bkc_r <= 4'h0;
      link_lost_r <= 1'b0;
      crc_flag_r <= 1'b0;
      st_flag_r <= 1'b0;
    end else begin
      pkt_sts_r <= (rd_pkt_sts ? 4'h0 : pkt_sts_r) | pkt_sts_ev;
      lane01_r <= (rd_l01 ? 3'b000 : lane01_r) | lane01_ev;
      lane23_r <= (rd_l23 ? 3'b000 : lane23_r) | lane23_ev;
      clk_lane_r <= (rd_clk ? 2'b00 : clk_lane_r) | clk_lane_ev;
      bkc_r <= (rd_bkc ? 4'h0 : bkc_r) | bkc_ev;
      link_lost_r <= (rd_gs ? 1'b0 : link_lost_r) | link_lost_ev;
      crc_flag_r <= (clr_crc ? 1'b0 : crc_flag_r) | bc_crc_err_ev;
      st_flag_r <= (clr_st ? 1'b0 : st_flag_r) | (bc_crc_err_ev && selftest_active);
    end
  end

  // interrupt bank: set beats clear
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_sts_r <= 6'h00;
      irq_en_r <= 6'h00;
      irq <= 1'b0;
    end else begin
      irq_sts_r <= (irq_sts_r & ~(wr_irq_clr ? reg_wdata[5:0] : 6'h00)) | irq_ev;
      if (reg_wr && reg_addr == `SLD_ADDR_IRQ_EN)
        irq_en_r <= reg_wdata[5:0];
      irq <= |(irq_sts_r & irq_en_r);
    end
  end

  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `SLD_ADDR_BK_CTL: rdata_nxt = bk_ctl_r;
      `SLD_ADDR_GEN_STS: rdata_nxt = {3'b000, |bkc_r, st_flag_r, crc_flag_r,
                                      link_lost_r, link_up};
      `SLD_ADDR_ST_CNT: rdata_nxt = st_cnt_r;
      `SLD_ADDR_CRC_LO: rdata_nxt = crc_cnt_r[7:0];
      `SLD_ADDR_CRC_HI: rdata_nxt = crc_cnt_r[15:8];
      `SLD_ADDR_PKT_CNT: rdata_nxt = pkt_cnt_r;
      `SLD_ADDR_PKT_STS: rdata_nxt = {4'h0, pkt_sts_r};
      `SLD_ADDR_LANE01: rdata_nxt = {5'b00000, lane01_r};
      `SLD_ADDR_LANE23: rdata_nxt = {5'b00000, lane23_r};
      `SLD_ADDR_CLK_LANE: rdata_nxt = {6'b000000, clk_lane_r};
      `SLD_ADDR_ECC_SEL: rdata_nxt = ecc_inject_sel;
      `SLD_ADDR_BKC_STS: rdata_nxt = {4'h0, bkc_r};
      `SLD_ADDR_IRQ_STS: rdata_nxt = {2'b00, irq_sts_r};
      `SLD_ADDR_IRQ_EN: rdata_nxt = {2'b00, irq_en_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

//--- dv/sld_diag_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sld_diag_regs_assertions (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire link_up,
  input wire bc_crc_err_ev,
  input wire pkt_err_ev,
  input wire [3:0] pkt_sts_ev,
  input wire [7:0] ecc_inject_sel,
  input wire [2:0] link_detect_timer,
  input wire irq
);
  wire wr49 = reg_wr && reg_addr == 8'h49;
  wire wr77 = reg_wr && reg_addr == 8'h77;
  wire wr91 = reg_wr && reg_addr == 8'h91;
  wire rd52 = reg_rd && reg_addr == 8'h52;
  wire rd54 = reg_rd && reg_addr == 8'h54;
  wire rd5c = reg_rd && reg_addr == 8'h5c;
  wire rd5d = reg_rd && reg_addr == 8'h5d;
  wire calm = !bc_crc_err_ev && !reg_wr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  timer_load_a: assert property (wr49 |=> link_detect_timer == $past(reg_wdata[4:2]))
    else $error("timer not loaded");
  timer_hold_a: assert property (!wr49 |=> $stable(link_detect_timer))
    else $error("timer changed");
  ecc_load_a: assert property (wr77 |=> ecc_inject_sel == $past(reg_wdata))
    else $error("ecc select not loaded");
  link_shown_a: assert property (rd52 |=> reg_rdata[0] == $past(link_up))
    else $error("link bit wrong");
  pkt_restart_a: assert property (rd5c && !pkt_err_ev ##1 !pkt_err_ev ##1 rd5c |=> reg_rdata == 0)
    else $error("packet count kept");
  st_hold_a: assert property (rd54 && calm ##1 calm ##1 rd54 |=> reg_rdata == $past(reg_rdata, 2))
    else $error("self-test count moved");
  pkt_flag_a: assert property (pkt_sts_ev[0] ##1 !rd5d ##1 rd5d |=> reg_rdata[0])
    else $error("length flag lost");
  irq_mask_a: assert property (wr91 && reg_wdata == 0 ##1 !reg_wr |=> !irq)
    else $error("irq while masked");
  cover property (rd5c ##1 reg_rdata != 0);
  cover property (rd54 ##1 reg_rdata == 8'hff);
  cover property (irq);
endmodule
bind sld_diag_regs sld_diag_regs_assertions sld_diag_regs_assertions_inst (.ref_clk, .nrst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_up, .bc_crc_err_ev, .pkt_err_ev,
  .pkt_sts_ev, .ecc_inject_sel, .link_detect_timer, .irq);
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, link_up = 0, selftest_active = 0, irq;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, ecc_inject_sel, d;
  logic [2:0] link_detect_timer;
  logic [18:0] ev = 0;
  logic [7:0] ad [6] = '{8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h79, 8'h52};
  int base [7] = '{0, 4, 7, 10, 12, 16, 17};
  int err_total = 0, samples_checked = 0, cyc = 0, n;
  sld_diag_regs sld_diag_regs_inst (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .link_up, .link_lost_ev(ev[16]), .selftest_active, .bc_crc_err_ev(ev[17]),
    .pkt_err_ev(ev[18]), .pkt_sts_ev(ev[3:0]), .lane01_ev(ev[6:4]), .lane23_ev(ev[9:7]),
    .clk_lane_ev(ev[11:10]), .bkc_ev(ev[15:12]), .ecc_inject_sel, .link_detect_timer, .irq);
  always #25 ref_clk = ~ref_clk;
  task automatic complete_run;
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // runs are well under 2000 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      complete_run;
    end
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [7:0] sat(input int k);
    return k > 255 ? 8'hff : 8'(k);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic fire(input logic [18:0] v, input int k);
    repeat (k) begin
      @(posedge ref_clk);
      ev <= v;
      @(posedge ref_clk);
      ev <= 0;
    end
  endtask
  initial begin
    void'($urandom(41409));
    repeat (12) @(posedge ref_clk);
    nrst <= 1;
    rd(8'h49);
    chk("ctrl_rst", 8'h00, d);
    for (int p = 0; p < 2; p++) begin
      n = p ? 260 : $urandom_range(1, 40);
      {link_up, selftest_active} <= {p[0], 1'b1};
      wr(8'h49, 8'h03);
      fire(19'h2_0000, n);
      rd(8'h54);
      chk("st_cnt", sat(n), d);
      rd(8'h54);
      chk("st_cnt_keep", sat(n), d);
      rd(8'h55);
      chk("crc_lo", n[7:0], d);
      rd(8'h56);
      chk("crc_hi", n[15:8], d);
      rd(8'h52);
      chk("gen", {4'h0, 2'b11, 1'b0, link_up}, d);
    end
    n = $urandom_range(0, 7);
    wr(8'h49, {3'h0, n[2:0], 2'h3});
    rd(8'h55);
    chk("crc_clr", 8'h00, d);
    chk("timer", {5'h0, n[2:0]}, {5'h0, link_detect_timer});
    for (int j = 0; j < 6; j++)
      for (int i = base[j]; i < base[j + 1]; i++) begin
        fire(19'h1 << i, 1);
        rd(ad[j]);
        chk("flag", 8'h1 << (i - base[j] + j / 5), d & ~{7'h0, j == 5});
        rd(ad[j]);
        chk("flag_clr", 8'h00, d & ~{7'h0, j == 5});
      end
    n = $urandom_range(1, 30);
    fire(19'h4_0000, n);
    rd(8'h5c);
    chk("pkt_cnt", n[7:0], d);
    rd(8'h5c);
    chk("pkt_cnt_rd", 8'h00, d);
    n = $urandom;
    wr(8'h77, n[7:0]);
    rd(8'h77);
    chk("ecc_sel", n[7:0], ecc_inject_sel);
    chk("ecc_rd", n[7:0], d);
    rd(8'h00);
    chk("unmapped", 8'h00, d);
    wr(8'h92, 8'hff);
    wr(8'h91, 8'h04);
    fire(19'h4_0000, 1);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_set", 8'h01, {7'h0, irq});
    rd(8'h90);
    chk("irq_sts", 8'h04, d);
    wr(8'h91, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_mask", 8'h00, {7'h0, irq});
    complete_run;
  end
endmodule
`default_nettype wire
